// ==== rtl/ovr_fetch_if.sv ====
`timescale 1ns/1ps
interface ovr_fetch_if;
    logic                 start;
    ovr_pkg::ovr_byte_t   addr;
    logic                 done;
    ovr_pkg::ovr_byte_t   data;

    modport seq (
        output start,
        output addr,
        input  done,
        input  data
    );

    modport fetch (
        input  start,
        input  addr,
        output done,
        output data
    );
endinterface : ovr_fetch_if

// ==== rtl/ovr_params.svh ====
`ifndef OVR_PARAMS_SVH
`define OVR_PARAMS_SVH

`define OVR_OFS_VERSION   32'h0000_0000
`define OVR_OFS_ROM_PORT  32'h0000_0004
`define OVR_VER_MAJOR     8'h01
`define OVR_VER_MINOR     8'h10
`define OVR_PRESENT_BIT   24
`define OVR_CLEAR_BIT     31
`define OVR_LAUNCH_BIT    25
`define OVR_BYTE_LSB      16
`define OVR_OPT_ROM_PTR   8'h20
`define OVR_OPT_BYTE_IDX  8'h06
`define OVR_OPT_FLAG_BIT  5
`define OVR_NODE_INFO_LEN 20
`define OVR_RESET_BYTE    8'h00
`define OVR_RESET_ADDR    8'h00

`endif

// ==== rtl/ovr_pkg.sv ====
package ovr_pkg;

    typedef enum logic [0:0] {
        OVR_REG_VERSION,
        OVR_REG_ROM_PORT
    } ovr_reg_t;

    typedef enum {
        OVR_ST_STRAP,
        OVR_ST_AUTO,
        OVR_ST_IDLE,
        OVR_ST_CLEAR,
        OVR_ST_READ
    } ovr_state_t;

    typedef logic [7:0] ovr_byte_t;

endpackage : ovr_pkg

// ==== rtl/ovr_rom_fetch.sv ====
`timescale 1ns/1ps
`include "ovr_params.svh"
module ovr_rom_fetch (
    input  wire logic               clk_i,      // Controller clock.
    input  wire logic               arst_n_i,   // Async reset, low.
    ovr_fetch_if.fetch              fch,        // Byte fetch requests.
    output logic                    rom_req_o,  // EEPROM byte request.
    output ovr_pkg::ovr_byte_t      rom_addr_o, // EEPROM byte address.
    input  wire logic               rom_ack_i,  // EEPROM byte ready.
    input  wire ovr_pkg::ovr_byte_t rom_data_i  // EEPROM byte value.
);
    import ovr_pkg::*;

    logic      busy_q;
    ovr_byte_t addr_q;
    ovr_byte_t data_q;
    logic      done_q;
    logic      take;

    // The request holds until the EEPROM side acknowledges it.
    assign take = busy_q & rom_ack_i;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_q <= 1'b0;
            addr_q <= `OVR_RESET_ADDR;
        end else if (!busy_q && fch.start) begin
            busy_q <= 1'b1;
            addr_q <= fch.addr;
        end else if (take) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_q <= `OVR_RESET_BYTE;
            done_q <= 1'b0;
        end else begin
            done_q <= take;
            if (take) begin
                data_q <= rom_data_i;
            end
        end
    end

    assign rom_req_o  = busy_q;
    assign rom_addr_o = addr_q;
    assign fch.done   = done_q;
    assign fch.data   = data_q;
endmodule : ovr_rom_fetch

// ==== rtl/ovr_top.sv ====
`timescale 1ns/1ps
`include "ovr_params.svh"
module ovr_top (
    input  wire logic               clk_i,         // Controller clock.
    input  wire logic               arst_n_i,      // Async reset, low.
    input  wire logic               hsel_i,        // Slave select.
    input  wire logic [31:0]        haddr_i,       // Byte address.
    input  wire logic [1:0]         htrans_i,      // Transfer type.
    input  wire logic               hwrite_i,      // Write when high.
    input  wire logic [2:0]         hsize_i,       // Transfer size.
    input  wire logic [31:0]        hwdata_i,      // Write data.
    input  wire logic               hready_i,      // Bus ready.
    output logic                    hreadyout_o,   // Slave ready.
    output logic [31:0]             hrdata_o,      // Read data.
    output logic                    hresp_o,       // Always OKAY.
    input  wire logic               eeprom_det_i,  // EEPROM detected.
    output logic                    rom_req_o,     // EEPROM byte request.
    output ovr_pkg::ovr_byte_t      rom_addr_o,    // EEPROM byte address.
    input  wire logic               rom_ack_i,     // EEPROM byte ready.
    input  wire ovr_pkg::ovr_byte_t rom_data_i,    // EEPROM byte value.
    input  wire logic [4:0]         node_idx_i,    // Node info index.
    output ovr_pkg::ovr_byte_t      node_byte_o,   // Node info byte.
    output logic                    node_valid_o   // Node info loaded.
);
    import ovr_pkg::*;

    localparam int NODE_LEN = `OVR_NODE_INFO_LEN;

    // Register select for one aligned byte address; hit is low when
    // the address maps to nothing.
    function automatic logic ovr_hit(input logic [31:0] a);
        ovr_hit = (a == `OVR_OFS_VERSION) | (a == `OVR_OFS_ROM_PORT);
    endfunction : ovr_hit

    function automatic ovr_reg_t ovr_decode(input logic [31:0] a);
        ovr_decode = (a == `OVR_OFS_ROM_PORT) ? OVR_REG_ROM_PORT
                                              : OVR_REG_VERSION;
    endfunction : ovr_decode

    ovr_fetch_if fch_if ();

    ovr_rom_fetch ovr_rom_fetch_i (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .fch        (fch_if.fetch),
        .rom_req_o  (rom_req_o),
        .rom_addr_o (rom_addr_o),
        .rom_ack_i  (rom_ack_i),
        .rom_data_i (rom_data_i)
    );

    // Bus slave state. The data phase keeps what its address phase asked
    // for, because write data only arrives one cycle after the address
    // and the bus may show the next address by then.
    logic        dp_valid_q;
    logic        dp_write_q;
    logic        dp_hit_q;
    ovr_reg_t    dp_reg_q;
    logic        rd_wait_q;
    logic [31:0] hrdata_q;

    // Block state.
    ovr_state_t  state_q;
    ovr_state_t  state_d;
    logic        present_q;
    logic        clear_q;
    logic        launch_q;
    ovr_byte_t   sw_addr_q;
    ovr_byte_t   rd_byte_q;
    logic        opt_rom_q;
    ovr_byte_t   auto_idx_q;
    logic        auto_busy_q;
    logic        node_valid_q;
    ovr_byte_t   node_byte_q;
    ovr_byte_t   node_mem [NODE_LEN];

    // Address phase and data phase decode. A write commits at the end of
    // its data phase, so every register update below sees the bus word
    // of that same cycle.
    wire        addr_take  = hsel_i & htrans_i[1] & hready_i;
    wire        wr_commit  = dp_valid_q & dp_write_q & dp_hit_q & hready_i;
    wire        dp_is_port = (dp_reg_q == OVR_REG_ROM_PORT);
    wire        wr_port    = wr_commit & dp_is_port;
    wire        sw_clear   = wr_port & hwdata_i[`OVR_CLEAR_BIT];
    wire        sw_launch  = wr_port & hwdata_i[`OVR_LAUNCH_BIT];
    wire        rd_capture = rd_wait_q;

    // Register images as software sees them.
    wire [31:0] version_word = {
        7'h00,
        present_q,
        `OVR_VER_MAJOR,
        8'h00,
        `OVR_VER_MINOR
    };

    wire ovr_byte_t opt_ptr = opt_rom_q ? `OVR_OPT_ROM_PTR : 8'h00;

    wire [31:0] port_word = {
        clear_q,
        5'h00,
        launch_q,
        1'b0,
        rd_byte_q,
        8'h00,
        opt_ptr
    };

    wire [31:0] rd_mux = !dp_hit_q                      ? 32'h0000_0000 :
                         dp_is_port                     ? port_word
                                                        : version_word;

    // Bus slave: writes complete with no wait state, reads take one
    // wait state so that a read right after a write sees its effect.
    // The phase registers only move while the bus is ready, so a stalled
    // data phase keeps pointing at its own register.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
        end else if (hready_i) begin
            dp_valid_q <= addr_take;
            dp_write_q <= hwrite_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dp_hit_q <= 1'b0;
            dp_reg_q <= OVR_REG_VERSION;
        end else if (hready_i) begin
            dp_hit_q <= ovr_hit(haddr_i);
            dp_reg_q <= ovr_decode(haddr_i);
        end
    end

    // Ready is low for exactly one cycle of every read data phase.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_wait_q <= 1'b0;
        end else begin
            rd_wait_q <= addr_take & ~hwrite_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_capture) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hreadyout_o = ~rd_wait_q;
    assign hrdata_o    = hrdata_q;
    assign hresp_o     = 1'b0;

    // Sequencer. After reset it samples the strap, runs the automatic
    // load if an EEPROM is there, then serves one software request at a
    // time; a clear is served before a launch that waits beside it.
    wire fetch_done = fch_if.done;
    wire auto_last  = (auto_idx_q == 8'(NODE_LEN - 1));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            OVR_ST_STRAP: begin
                state_d = eeprom_det_i ? OVR_ST_AUTO : OVR_ST_IDLE;
            end
            OVR_ST_AUTO: begin
                if (fetch_done && auto_last) begin
                    state_d = OVR_ST_IDLE;
                end
            end
            OVR_ST_IDLE: begin
                if (clear_q) begin
                    state_d = OVR_ST_CLEAR;
                end else if (launch_q) begin
                    state_d = OVR_ST_READ;
                end
            end
            OVR_ST_CLEAR: begin
                state_d = OVR_ST_IDLE;
            end
            OVR_ST_READ: begin
                if (fetch_done) begin
                    state_d = OVR_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= OVR_ST_STRAP;
        end else begin
            state_q <= state_d;
        end
    end

    // Named views of the state, used by the control logic below.
    wire in_strap = (state_q == OVR_ST_STRAP);
    wire in_auto  = (state_q == OVR_ST_AUTO);
    wire in_idle  = (state_q == OVR_ST_IDLE);
    wire in_clear = (state_q == OVR_ST_CLEAR);
    wire in_read  = (state_q == OVR_ST_READ);
    wire auto_got = in_auto & fetch_done;

    // The detect level is a strap: caught in the first cycle after the
    // reset release and held until the next reset.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            present_q <= 1'b0;
        end else if (in_strap) begin
            present_q <= eeprom_det_i;
        end
    end

    // Fetch requests: one per automatic byte, one per software read.
    wire auto_start = in_auto & ~auto_busy_q;
    wire sw_start   = in_idle & ~clear_q & launch_q;

    assign fch_if.start = auto_start | sw_start;
    assign fch_if.addr  = auto_start ? auto_idx_q : sw_addr_q;

    // One automatic request in flight at a time; the next waits for done.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            auto_busy_q <= 1'b0;
        end else if (auto_start) begin
            auto_busy_q <= 1'b1;
        end else if (fetch_done) begin
            auto_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            auto_idx_q <= `OVR_RESET_ADDR;
        end else if (auto_got) begin
            auto_idx_q <= auto_idx_q + 8'h01;
        end
    end

    // Node information block storage, filled by the automatic load.
    always_ff @(posedge clk_i) begin
        if (auto_got) begin
            node_mem[auto_idx_q[4:0]] <= fch_if.data;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            node_valid_q <= 1'b0;
        end else if (auto_got && auto_last) begin
            node_valid_q <= 1'b1;
        end
    end

    wire node_idx_ok = (32'(node_idx_i) < NODE_LEN) & node_valid_q;

    // The port is a flop: an index set before an edge shows its byte
    // after that edge. Indices past the block, or a block not yet loaded,
    // read zero.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            node_byte_q <= `OVR_RESET_BYTE;
        end else if (node_idx_ok) begin
            node_byte_q <= node_mem[node_idx_i];
        end else begin
            node_byte_q <= 8'h00;
        end
    end

    assign node_byte_o  = node_byte_q;
    assign node_valid_o = node_valid_q;

    // The option-ROM flag comes from the automatically loaded byte 6h.
    wire opt_byte = auto_got & (auto_idx_q == `OVR_OPT_BYTE_IDX);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opt_rom_q <= 1'b0;
        end else if (opt_byte) begin
            opt_rom_q <= fch_if.data[`OVR_OPT_FLAG_BIT];
        end
    end

    // Access port control bits. Software may only set them; the sequencer
    // clears each one when its operation has finished, which is how
    // software learns that the operation is over.
    wire clear_done = in_clear;
    wire read_done  = in_read & fetch_done;

    // A set written in the cycle the clear completes starts a new clear.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clear_q <= 1'b0;
        end else if (sw_clear) begin
            clear_q <= 1'b1;
        end else if (clear_done) begin
            clear_q <= 1'b0;
        end
    end

    // Launch is taken only when no clear or launch is pending or running, and a word
    // that asks for both a clear and a launch is taken as a clear only.
    wire launch_busy = launch_q | clear_q | sw_clear;
    wire launch_ok   = sw_launch & ~launch_busy;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            launch_q <= 1'b0;
        end else if (launch_ok) begin
            launch_q <= 1'b1;
        end else if (read_done) begin
            launch_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sw_addr_q <= `OVR_RESET_ADDR;
        end else if (clear_done) begin
            sw_addr_q <= `OVR_RESET_ADDR;
        end else if (read_done) begin
            sw_addr_q <= sw_addr_q + 8'h01;
        end
    end

    // Only a completed read loads the byte; a clear leaves it alone.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_byte_q <= `OVR_RESET_BYTE;
        end else if (read_done) begin
            rd_byte_q <= fch_if.data;
        end
    end

    // Software is expected to check the present flag first; without an
    // EEPROM a launch still runs and returns whatever the port answers.
    wire unused_ok = ^{hsize_i, dp_valid_q};

endmodule : ovr_top

// ==== testbench/ovr_eeprom_model.sv ====
`timescale 1ns/1ps
module ovr_eeprom_model (
    input  wire logic               clk_i,    // Clock.
    input  wire logic               arst_n_i, // Reset, low.
    input  wire logic               slow_i,   // Answer late.
    input  wire logic               opt_i,    // Option flag of byte 6.
    input  wire logic               req_i,    // Byte request.
    input  wire ovr_pkg::ovr_byte_t addr_i,   // Byte address.
    output logic                    ack_o,    // Byte ready.
    output ovr_pkg::ovr_byte_t      data_o    // Byte value.
);
    import ovr_pkg::*;
    logic [3:0] wait_q;
    ovr_byte_t  data_q;
    ovr_byte_t  mem_d;
    logic       flag_d;
    // Content is address xor a5, with bit 5 of byte 6 set by opt_i.
    assign flag_d = (addr_i == 8'h06) ? opt_i : ~addr_i[5];
    assign mem_d  = {addr_i[7:6] ^ 2'h2, flag_d, addr_i[4:0] ^ 5'h05};
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q <= 4'h0;
            ack_o  <= 1'b0;
            data_q <= 8'h00;
        end else if (ack_o || !req_i) begin
            wait_q <= 4'h0;
            ack_o  <= 1'b0;
        end else if (wait_q >= {slow_i, slow_i, 2'h0}) begin
            ack_o  <= 1'b1;
            data_q <= mem_d;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
    // Outside the ack cycle the line shows a stale, inverted value.
    assign data_o = ack_o ? data_q : ~data_q;
endmodule : ovr_eeprom_model

// ==== testbench/ovr_top_props.sv ====
`timescale 1ns/1ps
module ovr_top_props (
    input wire logic               clk_i,        // Clock.
    input wire logic               arst_n_i,     // Reset, low.
    input wire logic               hsel_i,       // Select.
    input wire logic [31:0]        haddr_i,      // Address.
    input wire logic [1:0]         htrans_i,     // Type.
    input wire logic               hwrite_i,     // Write.
    input wire logic               hready_i,     // Ready in.
    input wire logic               hreadyout_o,  // Ready out.
    input wire logic [31:0]        hrdata_o,     // Read data.
    input wire logic               hresp_o,      // Response.
    input wire logic               eeprom_det_i, // Strap.
    input wire logic               rom_req_o,    // Request.
    input wire ovr_pkg::ovr_byte_t rom_addr_o,   // Address.
    input wire logic               rom_ack_i,    // Ack.
    input wire logic [4:0]         node_idx_i,   // Index.
    input wire ovr_pkg::ovr_byte_t node_byte_o,  // Node byte.
    input wire logic               node_valid_o  // Loaded.
);
    import ovr_pkg::*;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence rd_any;
        hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    endsequence
    sequence rd_at(logic [31:0] a);
        rd_any ##0 haddr_i == a;
    endsequence
    sequence rd_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("response not okay");
    a_read_wait: assert property (rd_any |=> rd_wait)
        else $error("read wait state wrong");
    a_ver_value: assert property (rd_at(32'h0) |-> ##2
        hrdata_o[31:25] == 7'h00 && hrdata_o[23:0] == 24'h01_0010)
        else $error("version value wrong");
    a_ver_present: assert property (rd_at(32'h0) |-> ##2
        hrdata_o[24] == eeprom_det_i)
        else $error("present flag wrong");
    a_port_rsvd: assert property (rd_at(32'h4) |-> ##2
        hrdata_o[30:26] == 5'h00 && !hrdata_o[24] && hrdata_o[15:8] == 8'h00)
        else $error("access port reserved bits set");
    a_opt_ptr: assert property (rd_at(32'h4) |-> ##2
        hrdata_o[7:0] inside {8'h00, 8'h20}
        && (eeprom_det_i || hrdata_o[7:0] == 8'h00))
        else $error("option pointer wrong");
    a_req_hold: assert property (rom_req_o && !rom_ack_i |=>
        rom_req_o && $stable(rom_addr_o))
        else $error("request not held");
    a_req_done: assert property (rom_req_o && rom_ack_i |=> !rom_req_o)
        else $error("request not dropped");
    a_load_keep: assert property (node_valid_o |=> node_valid_o)
        else $error("node info lost");
    a_load_strap: assert property (!eeprom_det_i |-> !node_valid_o)
        else $error("node info without eeprom");
    a_node_zero: assert property (node_idx_i > 5'h13 || !node_valid_o |=>
        node_byte_o == 8'h00)
        else $error("node byte not zero");
endmodule : ovr_top_props

bind ovr_top ovr_top_props ovr_top_props_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o),
    .hrdata_o(hrdata_o), .hresp_o(hresp_o), .eeprom_det_i(eeprom_det_i),
    .rom_req_o(rom_req_o), .rom_addr_o(rom_addr_o), .rom_ack_i(rom_ack_i),
    .node_idx_i(node_idx_i), .node_byte_o(node_byte_o),
    .node_valid_o(node_valid_o)
);

// ==== testbench/ovr_top_tb_top.sv ====
`timescale 1ns/1ps
module ovr_top_tb_top;
    import ovr_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        det = 1'b1;
    logic        opt = 1'b1;
    logic        slow = 1'b0;
    logic [4:0]  nidx = 5'h00;
    logic        hrdy;
    logic [31:0] hrdata;
    logic        req;
    logic        ack;
    ovr_byte_t   raddr;
    ovr_byte_t   rdata;
    ovr_byte_t   nbyte;
    logic        nvalid;
    ovr_byte_t   last;
    ovr_byte_t   ptr;
    logic [31:0] w;
    int          num_errors = 0;
    int          cmp_count = 0;

    always #50 clk = ~clk;

    ovr_top ovr_top_i (
        .clk_i(clk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
        .hrdata_o(hrdata), .hresp_o(), .eeprom_det_i(det),
        .rom_req_o(req), .rom_addr_o(raddr), .rom_ack_i(ack),
        .rom_data_i(rdata), .node_idx_i(nidx), .node_byte_o(nbyte),
        .node_valid_o(nvalid)
    );

    ovr_eeprom_model ovr_eeprom_model_i (
        .clk_i(clk), .arst_n_i(arst_n), .slow_i(slow), .opt_i(opt),
        .req_i(req), .addr_i(raddr), .ack_o(ack), .data_o(rdata)
    );

    function automatic ovr_byte_t romb(input ovr_byte_t a);
        romb = a ^ 8'ha5;
        if (a == 8'h06) romb[5] = opt;
    endfunction : romb

    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Samples ready at the falling edge, so the value matches the next
    // rising edge; returns just after that rising edge.
    task automatic rdy(output logic [31:0] d);
        @(negedge clk);
        while (hrdy !== 1'b1) @(negedge clk);
        d = hrdata;
        @(posedge clk);
    endtask : rdy

    task automatic xfer(input logic [31:0] a, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd);
        logic [31:0] tmp;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        rdy(tmp);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy(rd);
    endtask : xfer

    task automatic poll(input logic [31:0] m);
        do xfer(32'h4, 1'b0, 32'h0, w); while ((w & m) !== 32'h0);
    endtask : poll

    task automatic launch_rd(input ovr_byte_t a);
        xfer(32'h4, 1'b1, 32'h0200_0000, w);
        poll(32'h0200_0000);
        chk(w, {8'h00, romb(a), 8'h00, ptr});
        last = romb(a);
    endtask : launch_rd

    task automatic t_boot(input logic d, input logic o);
        det    <= d;
        opt    <= o;
        arst_n <= 1'b0;
        ptr = (d && o) ? 8'h20 : 8'h00;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        xfer(32'h0, 1'b0, 32'h0, w);
        chk(w, {7'h00, d, 8'h01, 8'h00, 8'h10});
        if (w[24]) begin
            while (nvalid !== 1'b1) @(posedge clk);
            for (int i = 0; i < 20; i++) begin
                nidx <= i[4:0];
                @(posedge clk);
                @(negedge clk);
                chk({24'h0, nbyte}, {24'h0, romb(i[7:0])});
                @(posedge clk);
            end
            xfer(32'h4, 1'b0, 32'h0, w);
            chk(w & 32'hff00_ffff, {24'h0, ptr});
        end
    endtask : t_boot

    task automatic t_reads();
        launch_rd(8'h00);
        launch_rd(8'h01);
        xfer(32'h4, 1'b1, 32'h8000_0000, w);
        poll(32'h8000_0000);
        chk(w, {8'h00, last, 8'h00, ptr});
        slow <= 1'b1;
        launch_rd(8'h00);
    endtask : t_reads

    task automatic t_busy();
        xfer(32'h4, 1'b1, 32'h0200_0000, w);
        xfer(32'h4, 1'b1, 32'h0200_0000, w);
        poll(32'h0200_0000);
        chk(w, {8'h00, romb(8'h01), 8'h00, ptr});
        launch_rd(8'h02);
        slow <= 1'b0;
    endtask : t_busy

    task automatic t_refuse();
        xfer(32'h0, 1'b1, 32'hffff_ffff, w);
        xfer(32'h0, 1'b0, 32'h0, w);
        chk(w, 32'h0101_0010);
        xfer(32'h8, 1'b0, 32'h0, w);
        chk(w, 32'h0000_0000);
        xfer(32'h4, 1'b1, 32'h7cff_ffff, w);
        xfer(32'h4, 1'b0, 32'h0, w);
        chk(w, {8'h00, last, 8'h00, ptr});
    endtask : t_refuse

    initial begin
        t_boot(1'b1, 1'b1);
        t_reads();
        t_busy();
        t_refuse();
        t_boot(1'b1, 1'b0);
        t_boot(1'b0, 1'b0);
        conclude();
    end

    initial begin
        #3_000_000;
        num_errors++;
        conclude();
    end
endmodule : ovr_top_tb_top
